/* ncr_byte_reg.v */
// One software register of the bank with a write strobe.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ncr_defines.vh"

module ncr_byte_reg #(
    parameter WIDTH                 = `NCR_BYTE_W,
    parameter [WIDTH-1:0] RESET_VAL = `NCR_RESET_BYTE
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    output reg  [WIDTH-1:0] q_reg
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= RESET_VAL;
        end else if (wr_en) begin
            q_reg <= wr_data;
        end
    end

endmodule
`default_nettype wire

/* ncr_defines.vh */
// Constants for the oscillator tuning and phase register bank.
// Assumes inclusion by bare name from every design file of the bank.
`ifndef NCR_DEFINES_VH
`define NCR_DEFINES_VH

// ****************************************************************
// Register indices; the byte address on the bus is four times these.
// ****************************************************************
`define NCR_IDX_CTRL        8'h80
`define NCR_IDX_TUNE0       8'h82
`define NCR_IDX_TUNE1       8'h83
`define NCR_IDX_TUNE2       8'h84
`define NCR_IDX_TUNE3       8'h85
`define NCR_IDX_PHASE_LO    8'h86
`define NCR_IDX_PHASE_HI    8'h87
`define NCR_IDX_PHASE_LO_C1 8'h88

// ****************************************************************
// Storage slots inside the bank.
// ****************************************************************
`define NCR_SLOT_TUNE0       3'h0
`define NCR_SLOT_TUNE1       3'h1
`define NCR_SLOT_TUNE2       3'h2
`define NCR_SLOT_TUNE3       3'h3
`define NCR_SLOT_PHASE_LO    3'h4
`define NCR_SLOT_PHASE_HI    3'h5
`define NCR_SLOT_PHASE_LO_C1 3'h6
`define NCR_SLOT_CTRL        3'h7
`define NCR_NUM_SLOTS        8

// ****************************************************************
// Control register fields and reset values.
// ****************************************************************
`define NCR_CTRL_DDC1_EN_BIT 0
`define NCR_CTRL_LFSR_EN_BIT 2
`define NCR_CTRL_OSC_EN_BIT  5
`define NCR_RESET_BYTE       8'h00

// ****************************************************************
// Widths.
// ****************************************************************
`define NCR_BYTE_W   8
`define NCR_TUNE_W   32
`define NCR_PHASE_W  16
`define NCR_INDEX_W  8

`endif

/* ncr_phase_acc.v */
// Phase accumulator of the numeric oscillator.
// Assumes one accumulation per clock, the clock being the sample clock.
`timescale 1ns/1ps
`default_nettype none
`include "ncr_defines.vh"

module ncr_phase_acc #(
    parameter ACC_W   = `NCR_TUNE_W,
    parameter PHASE_W = `NCR_PHASE_W
) (
    input  wire               pclk,
    input  wire               presetn,
    input  wire               tune_active,
    input  wire               offset_active,
    input  wire [ACC_W-1:0]   tuning_word,
    input  wire [PHASE_W-1:0] offset_code,
    output reg  [ACC_W-1:0]   acc_reg,
    output reg  [PHASE_W-1:0] phase_reg
);

    wire [PHASE_W-1:0] offset_eff;
    wire [PHASE_W-1:0] acc_top;

    assign offset_eff = offset_active ? offset_code : {PHASE_W{1'b0}}; // RQ7
    assign acc_top    = acc_reg[ACC_W-1:ACC_W-PHASE_W];

    // ****************************************************************
    // Accumulation: one step of tuning_word per sample while tune_active, wrapping at 2^ACC_W; cleared to zero otherwise.
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg   <= {ACC_W{1'b0}};
            phase_reg <= {PHASE_W{1'b0}};
        end else if (tune_active) begin
            acc_reg   <= acc_reg + tuning_word; // RQ2 RQ13
            phase_reg <= acc_top + offset_eff; // RQ6 RQ13
        end else begin
            acc_reg   <= {ACC_W{1'b0}}; // RQ3
            phase_reg <= {PHASE_W{1'b0}};
        end
    end

endmodule
`default_nettype wire

/* ncr_regs.v */
// APB register bank for the numeric oscillator of the down-converter.
// Assumes pclk is the converter core sample clock and an APB master
// that holds each request until it samples pready high.
`timescale 1ns/1ps
`default_nettype none
`include "ncr_defines.vh"

// Contract
// RQ1: Tuning word is bytes 0x82 (low) through 0x85 (high), little order.
// RQ2: Oscillator frequency is tuning word over 2^32 times sample rate.
// RQ3: Tuning word acts only while the first down-converter enable is set.
// RQ4: Tuning bytes reset to zero, oscillator at DC.
// RQ5: Phase offset is low byte 0x86 and high byte 0x87.
// RQ6: Phase code is 2^16 times degrees over 360, one full cycle.
// RQ7: Phase offset acts only in down-conversion mode on the variant having it.
// RQ8: Software copies the low phase byte to every low repeat register.
// RQ9: Software copies the high phase byte to every high repeat register.
// RQ10: Software keeps first low repeat equal to the primary low byte.
// RQ11: Phase registers and repeats reset to zero degrees.
// RQ12: Software sets down-converter, dither sequence and oscillator enables together.
// RQ13: Accumulator adds tuning word per sample, offset added to upper bits.
// RQ14: All tuning and phase registers read back last written value.
module ncr_regs #(
    parameter HAS_DOWNCONVERTER = 1,
    parameter ADDR_W            = 12
) (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [ADDR_W-1:0]       paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    output wire [`NCR_TUNE_W-1:0]  oscillator_tuning_word,
    output wire [`NCR_PHASE_W-1:0] oscillator_phase_offset,
    output wire [`NCR_PHASE_W-1:0] osc_phase,
    output reg                     osc_running
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    wire [`NCR_INDEX_W-1:0] reg_index;
    wire                    word_aligned;
    wire                    upper_clear;
    reg                     slot_hit;
    reg  [2:0]              slot_sel;

    assign reg_index    = paddr[`NCR_INDEX_W+1:2];
    assign word_aligned = (paddr[1:0] == 2'b00);
    assign upper_clear  = (paddr[ADDR_W-1:`NCR_INDEX_W+2] == {(ADDR_W-`NCR_INDEX_W-2){1'b0}});

    always @* begin
        slot_hit = 1'b1;
        slot_sel = `NCR_SLOT_TUNE0;
        case (reg_index)
            `NCR_IDX_TUNE0: begin
                slot_sel = `NCR_SLOT_TUNE0;
            end
            `NCR_IDX_TUNE1: begin
                slot_sel = `NCR_SLOT_TUNE1;
            end
            `NCR_IDX_TUNE2: begin
                slot_sel = `NCR_SLOT_TUNE2;
            end
            `NCR_IDX_TUNE3: begin
                slot_sel = `NCR_SLOT_TUNE3;
            end
            `NCR_IDX_PHASE_LO: begin
                slot_sel = `NCR_SLOT_PHASE_LO;
            end
            `NCR_IDX_PHASE_HI: begin
                slot_sel = `NCR_SLOT_PHASE_HI;
            end
            `NCR_IDX_PHASE_LO_C1: begin
                slot_sel = `NCR_SLOT_PHASE_LO_C1;
            end
            `NCR_IDX_CTRL: begin
                slot_sel = `NCR_SLOT_CTRL;
            end
            default: begin
                slot_hit = 1'b0;
            end
        endcase
        if (!word_aligned || !upper_clear) begin
            slot_hit = 1'b0;
        end
    end

    // ****************************************************************
    // APB handshake.
    // ****************************************************************
    // The first access cycle raises pready; the edge that samples it
    // high commits the write and ends the transfer, so a write takes
    // effect exactly when the master sees the answer.
    wire access_cycle;
    wire access_done;
    wire commit_write;

    assign access_cycle = psel & penable;
    assign access_done  = access_cycle & pready;
    assign commit_write = access_done & pwrite & slot_hit;

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    wire [`NCR_BYTE_W-1:0] slot_q [0:`NCR_NUM_SLOTS-1];

    genvar g;
    generate
        for (g = 0; g < `NCR_NUM_SLOTS; g = g + 1) begin : g_slot
            localparam [2:0] SLOT_ID = g;
            wire wr_this;
            assign wr_this = commit_write & (slot_sel == SLOT_ID);
            ncr_byte_reg #(
                .WIDTH     (`NCR_BYTE_W),
                .RESET_VAL (`NCR_RESET_BYTE)
            ) u_reg (
                .pclk    (pclk),
                .presetn (presetn),
                .wr_en   (wr_this), // RQ14
                .wr_data (pwdata[`NCR_BYTE_W-1:0]),
                .q_reg   (slot_q[g]) // RQ4 RQ11
            );
        end
    endgenerate

    // ****************************************************************
    // Word assembly.
    // ****************************************************************
    wire [`NCR_BYTE_W-1:0] ctrl_q;
    wire                   ddc1_en;
    wire                   osc_en;
    wire                   variant_ok;
    wire                   ddc_mode;

    assign oscillator_tuning_word = {slot_q[`NCR_SLOT_TUNE3],
                                     slot_q[`NCR_SLOT_TUNE2],
                                     slot_q[`NCR_SLOT_TUNE1],
                                     slot_q[`NCR_SLOT_TUNE0]}; // RQ1
    assign oscillator_phase_offset = {slot_q[`NCR_SLOT_PHASE_HI],
                                      slot_q[`NCR_SLOT_PHASE_LO]}; // RQ5

    assign ctrl_q     = slot_q[`NCR_SLOT_CTRL];
    assign ddc1_en    = ctrl_q[`NCR_CTRL_DDC1_EN_BIT];
    assign osc_en     = ctrl_q[`NCR_CTRL_OSC_EN_BIT];
    assign variant_ok = (HAS_DOWNCONVERTER != 0);
    // The oscillator steps only with the first down-converter enabled.
    assign ddc_mode   = variant_ok & ddc1_en; // RQ3 RQ7

    // ****************************************************************
    // Oscillator.
    // ****************************************************************
    ncr_phase_acc #(
        .ACC_W   (`NCR_TUNE_W),
        .PHASE_W (`NCR_PHASE_W)
    ) u_acc (
        .pclk          (pclk),
        .presetn       (presetn),
        .tune_active   (ddc_mode), // RQ3
        .offset_active (ddc_mode), // RQ7
        .tuning_word   (oscillator_tuning_word), // RQ2
        .offset_code   (oscillator_phase_offset), // RQ6
        .acc_reg       (),
        .phase_reg     (osc_phase) // RQ13
    );

    // ****************************************************************
    // Status and bus answer.
    // ****************************************************************
    reg [31:0] prdata_next;
    reg        pready_next;
    reg        pslverr_next;

    always @* begin
        prdata_next  = prdata;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (access_cycle && !pready) begin
            pready_next  = 1'b1;
            pslverr_next = ~slot_hit;
            prdata_next  = 32'h0000_0000;
            if (slot_hit && !pwrite) begin
                prdata_next = {24'h00_0000, slot_q[slot_sel]}; // RQ14
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            osc_running <= 1'b0;
        end else begin
            prdata      <= prdata_next;
            pready      <= pready_next;
            pslverr     <= pslverr_next;
            osc_running <= ddc_mode & osc_en;
        end
    end

endmodule
`default_nettype wire

/* ncr_regs_checker.sv */
// Concurrent checks on the ports of the oscillator register bank.
// Assumes it is bound to ncr_regs, an APB slave with one wait state.
`timescale 1ns/1ps
`default_nettype none
module ncr_regs_checker #(
    parameter HAS_DOWNCONVERTER = 1
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] oscillator_tuning_word,
    input wire logic [15:0] oscillator_phase_offset,
    input wire logic [15:0] osc_phase,
    input wire logic        osc_running
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_ok = pready && pwrite && !pslverr;
    wire [31:0] tw = oscillator_tuning_word;
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_bad_addr: assert property (pready && (paddr[1:0] != 2'h0 ||
        paddr[11:10] != 2'h0) |-> pslverr && prdata == 32'h0)
        else $error("misaligned address not refused");
    a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_tune_high: assert property (wr_ok && paddr[9:2] == 8'h85 |=>
        tw[31:24] == $past(pwdata[7:0]))
        else $error("tuning top byte not stored");
    a_phase_high: assert property (wr_ok && paddr[9:2] == 8'h87 |=>
        oscillator_phase_offset[15:8] == $past(pwdata[7:0]))
        else $error("phase high byte not stored");
    a_tune_hold: assert property (!(pready && pwrite) |=> $stable(tw))
        else $error("tuning word changed without a write");
    a_reset_clear: assert property (disable iff (1'b0) !presetn |-> tw == 32'h0
        && oscillator_phase_offset == 16'h0 && osc_phase == 16'h0)
        else $error("registers not clear in reset");
    a_run_ctrl: assert property (wr_ok && paddr[9:2] == 8'h80 |-> ##2
        osc_running == ((($past(pwdata, 2) & 32'h21) == 32'h21)
        && HAS_DOWNCONVERTER != 0))
        else $error("running flag does not follow control");
    a_phase_step: assert property (osc_running && $past(osc_running) &&
        $past(tw) == tw && $past(tw, 2) == tw &&
        $stable(oscillator_phase_offset) |->
        16'(osc_phase - $past(osc_phase) - tw[31:16]) <= 16'h1)
        else $error("phase step differs from tuning word");
    cover property (wr_ok && paddr[9:2] == 8'h85);
    cover property (pready && pslverr);
    cover property ($rose(osc_running));
endmodule
bind ncr_regs ncr_regs_checker #(.HAS_DOWNCONVERTER(HAS_DOWNCONVERTER)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .oscillator_tuning_word(oscillator_tuning_word),
    .oscillator_phase_offset(oscillator_phase_offset),
    .osc_phase(osc_phase), .osc_running(osc_running));
`default_nettype wire

/* ncr_regs_tb.sv */
// Self-checking bench for the oscillator register bank over APB.
// Assumes the bank answers each access after one wait state.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ncr_regs_tb;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat, acc5;
    logic        pready, pslverr, rerr, osc_running;
    logic [31:0] tune;
    logic [15:0] off, osc_phase;
    int          i, mismatches, n_checks, cycles;

    ncr_regs #(.HAS_DOWNCONVERTER(1), .ADDR_W(12)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscillator_tuning_word(tune),
        .oscillator_phase_offset(off), .osc_phase(osc_phase),
        .osc_running(osc_running));

    // ****************************************************************
    // Clock, bus tasks and closing report
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge pclk);
        if (n == 20) mismatches++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic reset_dut();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic check_clear();
        `CHK(tune, 32'h0)
        `CHK(off, 16'h0)
        for (int k = 8'h80; k <= 8'h88; k++) if (k != 8'h81) begin
            xfer(1'b0, ad(8'(k)), 32'h0);
            `CHK({rerr, rdat}, 33'h0)
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        reset_dut();
        check_clear();
        for (i = 0; i < 4; i++)
            xfer(1'b1, ad(8'h82 + 8'(i)), 32'hdead_be00 | (32'h11 * (i + 1)));
        `CHK(tune, 32'h4433_2211)
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, ad(8'h82 + 8'(i)), 32'h0);
            `CHK({rerr, rdat}, 33'(32'h11 * (i + 1)))
        end
        xfer(1'b1, ad(8'h86), 32'h34);
        xfer(1'b1, ad(8'h87), 32'h12);
        xfer(1'b1, ad(8'h88), 32'h34);
        `CHK(off, 16'h1234)
        xfer(1'b0, ad(8'h88), 32'h0);
        `CHK(rdat, 32'h34)
        xfer(1'b1, ad(8'h89), 32'h12);
        `CHK(rerr, 1'b1)
        xfer(1'b0, ad(8'h81), 32'h0);
        `CHK({rerr, rdat}, 33'h1_0000_0000)
        xfer(1'b1, ad(8'h85) | 12'h1, 32'hff);
        `CHK(rerr, 1'b1)
        xfer(1'b1, ad(8'h8a), 32'hff);
        `CHK(rerr, 1'b1)
        `CHK(tune, 32'h4433_2211)
        `CHK(osc_phase, 16'h0)
        xfer(1'b1, ad(8'h80), 32'h25);
        repeat (5) @(posedge pclk);
        #1;
        acc5 = 32'h4433_2211 * 5;
        `CHK(osc_running, 1'b1)
        `CHK(osc_phase, acc5[31:16] + 16'h1234)
        xfer(1'b1, ad(8'h80), 32'h01);
        #1;
        `CHK(osc_running, 1'b0)
        xfer(1'b1, ad(8'h80), 32'h20);
        #1;
        `CHK(osc_phase, 16'h0)
        reset_dut();
        check_clear();
        end_of_test();
    end
endmodule
`default_nettype wire
